// [hdl/uhdir_pkg.sv]
// Package with constants, types and helpers of the half-duplex and infrared option.
//
// Contract
// - Control bit 1 turns infrared pulse coding on; not meant above 115.2 kbps.
// - Bit 2 keeps driver enable high while data pends, then until hold expires.
// - Half-duplex mode holds transmit interrupts until the shift register is empty.
// - Large-block bit 3 restores normal transmit interrupts: below threshold or empty.
// - Receive-enable bit 4 gates storing with half-duplex or infrared; then data is stored.
// - With half-duplex and infrared modes clear the receiver stores as normal full duplex.
// - Half-duplex with receive-enable and loopback clear disables the receiver, transmitting or not.
// - Receive-enable clear never allows the character timeout interrupt, in any mode.
// - Bits 7:5 give the hold delay in bit times, used only in half-duplex.
// - Hold delay starts with FIFO and shift register empty; FIFO write cancels it.
// - Driver enable rises one bit time before the first stop bit.
// - Loopback off, receive-enable clear: only plain mode stores, without timeout.
// - Loopback on: always store and interrupt; timeout only with receive-enable.
// - Encoder input high holds infrared output low and clears the pulse counter.
// - Encoder input low gives a pulse from the 7th to the 10th tick of a bit.
// - Sixteen ticks per bit; one is no pulse, zero is one pulse.
// - Decoder rests high; a falling edge drives it low for 16 ticks.
// - Receiver samples decoded input at tick 8 after its fall, then every 16.
// - Decoder accepts negative and positive pulses, keying on the falling edge.
// - Control bit 0 is reserved and has no effect.
// - Control register sits at address 010 only while line control 7:5 is 100.
package uhdir_pkg;

	localparam logic [2:0] ADDR_CONTROL      = 3'h2;
	localparam logic [2:0] ADDR_LINE_CONTROL = 3'h3;
	localparam logic [2:0] ADDR_STATUS       = 3'h5;
	localparam logic [2:0] LCR_WINDOW_KEY    = 3'h4;
	localparam int         LCR_KEY_LSB       = 5;

	localparam logic [7:0] CONTROL_RESET      = 8'h00;
	localparam logic [7:0] LINE_CONTROL_RESET = 8'h00;

	localparam logic [3:0] TICKS_LAST_IN_BIT = 4'hf;
	localparam logic [3:0] PULSE_RISE_TICK   = 4'h7;
	localparam logic [3:0] PULSE_FALL_TICK   = 4'ha;
	localparam logic [3:0] STROBE_FIRST_TICK = 4'h7;
	localparam logic [3:0] STROBE_NEXT_TICK  = 4'hf;
	localparam int         FRAME_BITS_RESET  = 10;

	typedef struct packed {
		logic [2:0] driver_hold_delay;
		logic       receive_enable_option;
		logic       large_block_option;
		logic       half_duplex_bus_enable;
		logic       infrared_mode_enable;
		logic       reserved;
	} uhdir_control_s;

	typedef struct packed {
		logic store;
		logic irq;
		logic timeout;
	} uhdir_rx_gate_s;

	typedef enum logic [1:0] {
		UHDIR_DRV_OFF  = 2'b00,
		UHDIR_DRV_ON   = 2'b01,
		UHDIR_DRV_HOLD = 2'b10
	} uhdir_drv_e;

	function automatic logic [3:0] uhdir_tick_inc(input logic [3:0] value);
		uhdir_tick_inc = value + 4'h1;
	endfunction : uhdir_tick_inc

endpackage : uhdir_pkg

// [hdl/uhdir_top.sv]
// Half-duplex bus driver control, infrared coding and receive gating.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

module uhdir_top #(
	parameter int FRAME_BITS = uhdir_pkg::FRAME_BITS_RESET
) (
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	input  wire logic [2:0]            reg_address,
	input  wire logic [7:0]            reg_write_data,
	input  wire logic                  reg_write,
	input  wire logic                  reg_read,
	output logic      [7:0]            reg_read_data,
	input  wire logic                  oversample_tick,
	input  wire logic                  bit_tick,
	input  wire logic                  tx_fifo_empty,
	input  wire logic                  tx_shift_empty,
	input  wire logic                  tx_fifo_write,
	input  wire logic                  tx_fifo_below_threshold,
	input  wire logic                  tx_before_stop,
	input  wire logic                  loopback_select,
	input  wire logic                  tx_from_uart,
	output logic                       tx_pin,
	input  wire logic                  rx_pin,
	output logic                       rx_to_receiver,
	output logic                       rx_sample_strobe,
	output logic                       driver_enable,
	output logic                       tx_irq_request,
	output uhdir_pkg::uhdir_rx_gate_s  rx_gate
);
	import uhdir_pkg::*;

	uhdir_control_s alternate_function_control;
	logic [7:0]     line_control;
	uhdir_drv_e     drv_state;
	uhdir_drv_e     next_drv_state;
	logic [2:0]     hold_count;
	logic [2:0]     next_hold_count;
	logic [3:0]     enc_count;
	logic           enc_out;
	logic           rx_prev;
	logic           dec_pending;
	logic [3:0]     dec_count;
	logic           dec_out;
	logic           dec_prev;
	logic           strobe_active;
	logic [3:0]     strobe_count;
	logic [7:0]     strobe_bits;
	logic           control_selected;
	logic           hd;
	logic           ir;
	logic           rcv;
	logic           tx_pending;
	logic           tx_all_empty;
	logic           rx_fall;
	logic           dec_fall;
	uhdir_rx_gate_s next_rx_gate;
	logic [7:0]     status_word;
	logic           hold_running;

	assign hd  = alternate_function_control.half_duplex_bus_enable;
	assign ir  = alternate_function_control.infrared_mode_enable;
	assign rcv = alternate_function_control.receive_enable_option;
	assign tx_all_empty = tx_fifo_empty && tx_shift_empty;
	assign tx_pending   = !tx_all_empty;

	// Status word: pulse coder, decoder, strobe and driver state.
	assign hold_running = (drv_state == UHDIR_DRV_HOLD);
	assign status_word  = {3'h0, enc_out, dec_out, strobe_active,
		hold_running, driver_enable};

	////////////////////////////////////////////////////////////////////////
	// Register port.

	// The control register is only visible through the line control key.
	assign control_selected = (reg_address == ADDR_CONTROL) &&
		(line_control[7:LCR_KEY_LSB] == LCR_WINDOW_KEY);

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			alternate_function_control <= CONTROL_RESET;
		end else if (reg_write && control_selected) begin
			alternate_function_control <= reg_write_data;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			line_control <= LINE_CONTROL_RESET;
		end else if (reg_write && reg_address == ADDR_LINE_CONTROL) begin
			line_control <= reg_write_data;
		end
	end

	// Read data stands for the one cycle after the read strobe.
	// Unmapped addresses and a locked control register read as zero.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			reg_read_data <= 8'h00;
		end else if (!reg_read) begin
			reg_read_data <= 8'h00;
		end else begin
			case (reg_address)
				ADDR_CONTROL: begin
					if (control_selected) begin
						reg_read_data <= alternate_function_control;
					end else begin
						reg_read_data <= 8'h00;
					end
				end
				ADDR_LINE_CONTROL: begin
					reg_read_data <= line_control;
				end
				ADDR_STATUS: begin
					reg_read_data <= status_word;
				end
				default: begin
					reg_read_data <= 8'h00;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Line driver enable and hold delay.

	always_comb begin
		next_drv_state  = drv_state;
		next_hold_count = hold_count;
		case (drv_state)
			UHDIR_DRV_OFF: begin
				if (hd && tx_before_stop && tx_pending) begin
					next_drv_state = UHDIR_DRV_ON;
				end
			end
			UHDIR_DRV_ON: begin
				if (!hd) begin
					next_drv_state = UHDIR_DRV_OFF;
				end else if (tx_all_empty && !tx_fifo_write) begin
					next_hold_count = 3'h0;
					if (alternate_function_control.driver_hold_delay
							== 3'h0) begin
						next_drv_state = UHDIR_DRV_OFF;
					end else begin
						next_drv_state = UHDIR_DRV_HOLD;
					end
				end
			end
			UHDIR_DRV_HOLD: begin
				if (!hd) begin
					next_drv_state = UHDIR_DRV_OFF;
				end else if (tx_fifo_write || tx_pending) begin
					next_drv_state = UHDIR_DRV_ON;
				end else if (bit_tick) begin
					next_hold_count = hold_count + 3'h1;
					if (next_hold_count ==
							alternate_function_control.driver_hold_delay) begin
						next_drv_state = UHDIR_DRV_OFF;
					end
				end
			end
			default: begin
				next_drv_state = UHDIR_DRV_OFF;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			drv_state  <= UHDIR_DRV_OFF;
			hold_count <= 3'h0;
		end else begin
			drv_state  <= next_drv_state;
			hold_count <= next_hold_count;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			driver_enable <= 1'b0;
		end else begin
			driver_enable <= (next_drv_state != UHDIR_DRV_OFF);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit interrupt timing.

	// Clearing the large-block bit mid transfer falls back to shift-empty.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			tx_irq_request <= 1'b0;
		end else if (hd && !alternate_function_control.large_block_option)
				begin
			tx_irq_request <= tx_all_empty;
		end else begin
			tx_irq_request <= tx_fifo_below_threshold || tx_fifo_empty;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive gating.

	always_comb begin
		next_rx_gate.store   = 1'b1;
		next_rx_gate.irq     = 1'b1;
		next_rx_gate.timeout = rcv;
		if (!loopback_select && !rcv && (hd || ir)) begin
			next_rx_gate.store = 1'b0;
			next_rx_gate.irq   = 1'b0;
		end
		if (!hd && !ir) begin
			next_rx_gate.store = 1'b1;
		end
		if (rcv && hd) begin
			next_rx_gate.store = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rx_gate <= '0;
		end else begin
			rx_gate <= next_rx_gate;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Infrared encoder.

	// True when the next tick of the bit lies inside the pulse window.
	function automatic logic in_pulse_window(input logic [3:0] count);
		logic [3:0] tick;
		tick = uhdir_tick_inc(count);
		in_pulse_window = (tick >= PULSE_RISE_TICK) &&
			(tick < PULSE_FALL_TICK);
	endfunction : in_pulse_window

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			enc_count <= 4'h0;
		end else if (tx_from_uart) begin
			enc_count <= 4'h0;
		end else if (oversample_tick) begin
			enc_count <= uhdir_tick_inc(enc_count);
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			enc_out <= 1'b0;
		end else if (tx_from_uart) begin
			enc_out <= 1'b0;
		end else if (oversample_tick) begin
			enc_out <= in_pulse_window(enc_count);
		end
	end

	// Bit 0 of the control register is never looked at.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			tx_pin <= 1'b1;
		end else if (ir) begin
			tx_pin <= enc_out;
		end else begin
			tx_pin <= tx_from_uart;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Infrared decoder.

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rx_prev <= 1'b1;
		end else begin
			rx_prev <= rx_pin;
		end
	end

	// Either pulse polarity has one falling edge, which is what counts.
	assign rx_fall = rx_prev && !rx_pin;

	// A fall that meets a tick is served at once; keeping it pending
	// would restart the low phase one tick later and stretch it.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			dec_pending <= 1'b0;
		end else if (oversample_tick) begin
			dec_pending <= 1'b0;
		end else if (rx_fall) begin
			dec_pending <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			dec_out   <= 1'b1;
			dec_count <= 4'h0;
		end else if (oversample_tick && (dec_pending || rx_fall)) begin
			dec_out   <= 1'b0;
			dec_count <= 4'h0;
		end else if (oversample_tick && !dec_out) begin
			dec_count <= uhdir_tick_inc(dec_count);
			if (dec_count == TICKS_LAST_IN_BIT) begin
				dec_out <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rx_to_receiver <= 1'b1;
		end else if (ir) begin
			rx_to_receiver <= dec_out;
		end else begin
			rx_to_receiver <= rx_pin;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive sampling strobe.

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			dec_prev <= 1'b1;
		end else begin
			dec_prev <= rx_to_receiver;
		end
	end

	assign dec_fall = dec_prev && !rx_to_receiver;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			strobe_active    <= 1'b0;
			strobe_count     <= 4'h0;
			strobe_bits      <= 8'h00;
			rx_sample_strobe <= 1'b0;
		end else begin
			rx_sample_strobe <= 1'b0;
			if (!strobe_active && dec_fall) begin
				strobe_active <= 1'b1;
				strobe_count  <= 4'h0;
				strobe_bits   <= 8'h00;
			end else if (strobe_active && oversample_tick) begin
				strobe_count <= uhdir_tick_inc(strobe_count);
				if ((strobe_bits == 8'h00 &&
						strobe_count == STROBE_FIRST_TICK) ||
						(strobe_bits != 8'h00 &&
						strobe_count == STROBE_NEXT_TICK)) begin
					rx_sample_strobe <= 1'b1;
					strobe_count     <= 4'h0;
					strobe_bits      <= strobe_bits + 8'h01;
					if (strobe_bits == 8'(FRAME_BITS - 1)) begin
						strobe_active <= 1'b0;
					end
				end
			end
		end
	end

endmodule : uhdir_top

// [test/uhdir_properties.sv]
// Checker of the option block outputs against its inputs.
`timescale 1ns/1ps
module uhdir_properties #(
	parameter int FRAME_BITS = 10
) (
	input wire logic                     clock,
	input wire logic                     reset_n,
	input wire logic [2:0]               reg_address,
	input wire logic [7:0]               reg_write_data,
	input wire logic                     reg_write,
	input wire logic                     reg_read,
	input wire logic [7:0]               reg_read_data,
	input wire logic                     tx_fifo_empty,
	input wire logic                     tx_shift_empty,
	input wire logic                     tx_fifo_below_threshold,
	input wire logic                     tx_before_stop,
	input wire logic                     loopback_select,
	input wire logic                     tx_from_uart,
	input wire logic                     tx_pin,
	input wire logic                     driver_enable,
	input wire logic                     tx_irq_request,
	input wire uhdir_pkg::uhdir_rx_gate_s rx_gate
);
	import uhdir_pkg::*;
	logic [7:0] lc;
	logic [7:0] ct;
	logic       st_exp;
	logic       irq_exp;
	logic       pend;
	assign pend = ~(tx_fifo_empty & tx_shift_empty);
	assign st_exp = loopback_select | ct[4] | ~(ct[2] | ct[1]);
	assign irq_exp = (ct[2] & ~ct[3]) ? ~pend
		: (tx_fifo_below_threshold | tx_fifo_empty);
	////////////////////////////////////////
	// Shadow of the line control and control registers.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			lc <= 8'h00;
			ct <= 8'h00;
		end else if (reg_write) begin
			if (reg_address == 3'h3)
				lc <= reg_write_data;
			if (reg_address == 3'h2 && lc[7:5] == 3'h4)
				ct <= reg_write_data;
		end
	end
	////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_rd_idle; !reg_read |=> reg_read_data == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not idle");
	property p_irq; reset_n |=> tx_irq_request == $past(irq_exp); endproperty
	a_irq: assert property (p_irq)
		else $error("transmit interrupt wrong");
	property p_tmo; reset_n |=> rx_gate.timeout == $past(ct[4]); endproperty
	a_tmo: assert property (p_tmo)
		else $error("timeout gate wrong");
	property p_store;
		reset_n |=> rx_gate.store == $past(st_exp) &&
			rx_gate.irq == $past(st_exp);
	endproperty
	a_store: assert property (p_store)
		else $error("receive gate wrong");
	property p_drv_off; !ct[2] |=> !driver_enable; endproperty
	a_drv_off: assert property (p_drv_off)
		else $error("driver on outside half duplex");
	property p_drv_rise; ct[2] && tx_before_stop && pend |=> driver_enable;
	endproperty
	a_drv_rise: assert property (p_drv_rise)
		else $error("driver did not rise");
	property p_drv_hold; ct[2] && driver_enable && pend |=> driver_enable;
	endproperty
	a_drv_hold: assert property (p_drv_hold)
		else $error("driver dropped with data");
	property p_enc_idle; ct[1] && tx_from_uart ##1 ct[1] |=> !tx_pin;
	endproperty
	a_enc_idle: assert property (p_enc_idle)
		else $error("encoder output not low");
	property p_pulse; ct[1] && $rose(tx_pin) |-> tx_pin[*3] ##1 !tx_pin;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("pulse width wrong");
endmodule : uhdir_properties

// [test/uhdir_optics.sv]
// Far side optics: a mirror may couple the LED back to the photo diode.
`timescale 1ns/1ps
module uhdir_optics (
	input  wire logic tx_pin,
	input  wire logic mirror,
	input  wire logic invert,
	input  wire logic line,
	output logic      rx_pin
);
	// With the mirror the photo diode stage may invert; without it the line level passes.
	assign rx_pin = mirror ? (tx_pin ^ invert) : line;
endmodule : uhdir_optics

// [test/uhdir_bench.sv]
// Bench that drives the option block through registers and pins.
`timescale 1ns/1ps
module uhdir_bench;
	import uhdir_pkg::*;
	localparam int FB = 2;
	localparam int DLY = 2;
	logic       clock, reset_n, reg_write, reg_read, oversample_tick;
	logic [2:0] reg_address;
	logic [7:0] reg_write_data, reg_read_data, n, hi, lo, st;
	logic       bit_tick, tx_fifo_empty, tx_shift_empty, tx_fifo_write;
	logic       tx_before_stop, tx_fifo_below_threshold, loopback_select;
	logic       tx_from_uart, tx_pin, rx_pin, rx_to_receiver, w, s;
	logic       rx_sample_strobe, driver_enable, tx_irq_request;
	logic       mirror, invert;
	logic [7:0] mode [7] = '{8'h00, 8'h04, 8'h02, 8'h10, 8'h14, 8'h12,
		8'h01};
	int         n_errors, n_compared, cyc;
	uhdir_rx_gate_s rx_gate;
	uhdir_top #(.FRAME_BITS(FB)) DUT (
		.clock                   (clock),
		.reset_n                 (reset_n),
		.reg_address             (reg_address),
		.reg_write_data          (reg_write_data),
		.reg_write               (reg_write),
		.reg_read                (reg_read),
		.reg_read_data           (reg_read_data),
		.oversample_tick         (oversample_tick),
		.bit_tick                (bit_tick),
		.tx_fifo_empty           (tx_fifo_empty),
		.tx_shift_empty          (tx_shift_empty),
		.tx_fifo_write           (tx_fifo_write),
		.tx_fifo_below_threshold (tx_fifo_below_threshold),
		.tx_before_stop          (tx_before_stop),
		.loopback_select         (loopback_select),
		.tx_from_uart            (tx_from_uart),
		.tx_pin                  (tx_pin),
		.rx_pin                  (rx_pin),
		.rx_to_receiver          (rx_to_receiver),
		.rx_sample_strobe        (rx_sample_strobe),
		.driver_enable           (driver_enable),
		.tx_irq_request          (tx_irq_request),
		.rx_gate                 (rx_gate)
	);
	uhdir_optics u_optics (
		.tx_pin (tx_pin),
		.mirror (mirror),
		.invert (invert),
		.line   (1'b1),
		.rx_pin (rx_pin)
	);
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		bit_tick <= (cyc % 16 == 15);
	end
	////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_compared++;
		if (seen !== want) begin
			n_errors++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_address <= a;
		reg_write_data <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [2:0] a, input logic [7:0] want);
		@(posedge clock);
		reg_address <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 check(reg_read_data, want);
	endtask : rreg
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	initial begin
		#(50 * 3000);
		n_errors++;
		summarize();
	end
	////////////////////////////////////////
	initial begin
		{reset_n, reg_write, reg_read, tx_fifo_write, tx_before_stop} = '0;
		{reg_address, reg_write_data, mirror, invert} = '0;
		{loopback_select, tx_fifo_below_threshold, w} = '0;
		{oversample_tick, tx_fifo_empty, tx_shift_empty, tx_from_uart} = '1;
		{n_errors, n_compared} = '0;
		repeat (16) @(posedge clock);
		reset_n <= 1'b1;
		rreg(3'h2, 8'h00);
		wreg(3'h2, 8'hff);
		wreg(3'h3, 8'h80);
		rreg(3'h2, 8'h00);
		wreg(3'h2, 8'h5a);
		rreg(3'h2, 8'h5a);
		rreg(3'h7, 8'h00);
		$display("registers done");
		foreach (mode[i]) for (int l = 0; l < 2; l++) begin
			@(posedge clock) loopback_select <= l[0];
			wreg(3'h2, mode[i]);
			@(posedge clock);
			s = l[0] | mode[i][4] | ~(mode[i][2] | mode[i][1]);
			#1 check(rx_gate, {s, s, mode[i][4]});
		end
		$display("receive gating done");
		wreg(3'h2, 8'h04);
		@(posedge clock) {tx_fifo_empty, tx_shift_empty} <= 2'b00;
		@(posedge clock) tx_fifo_below_threshold <= 1'b1;
		repeat (2) @(posedge clock);
		#1 check(tx_irq_request, 1'b0);
		wreg(3'h2, 8'h0c);
		@(posedge clock);
		#1 check(tx_irq_request, 1'b1);
		wreg(3'h2, {3'(DLY), 5'h04});
		@(posedge clock);
		#1 check(tx_irq_request, 1'b0);
		$display("transmit interrupt done");
		@(posedge clock) tx_before_stop <= 1'b1;
		@(posedge clock) tx_before_stop <= 1'b0;
		#1 check(driver_enable, 1'b1);
		do @(posedge clock); while (bit_tick !== 1'b1);
		{tx_fifo_empty, tx_shift_empty} <= 2'b11;
		n = 8'h00;
		for (int k = 0; k < 200 && driver_enable !== 1'b0; k++) begin
			@(posedge clock);
			n += bit_tick;
			tx_fifo_write <= (n == 8'h01 && !w);
			w = w | (n == 8'h01);
			#1;
		end
		check(n, 8'(DLY + 1));
		check(driver_enable, 1'b0);
		rreg(3'h5, 8'h08);
		$display("driver enable done");
		wreg(3'h2, 8'h12);
		for (int v = 0; v < 2; v++) begin
			@(posedge clock) {mirror, invert} <= {1'b1, v == 0};
			repeat (40) @(posedge clock);
			tx_from_uart <= 1'b0;
			{hi, lo, st} = '0;
			for (int k = 0; k < 60; k++) begin
				@(posedge clock);
				tx_from_uart <= (k >= 15);
				#1;
				hi += tx_pin;
				lo += !rx_to_receiver;
				st += rx_sample_strobe;
			end
			check(hi, 8'h03);
			check(lo, 8'h10);
			check(st, 8'(FB));
		end
		$display("infrared done");
		summarize();
	end
endmodule : uhdir_bench
bind uhdir_top uhdir_properties #(.FRAME_BITS(FRAME_BITS)) u_chk (
	.clock                   (clock),
	.reset_n                 (reset_n),
	.reg_address             (reg_address),
	.reg_write_data          (reg_write_data),
	.reg_write               (reg_write),
	.reg_read                (reg_read),
	.reg_read_data           (reg_read_data),
	.tx_fifo_empty           (tx_fifo_empty),
	.tx_shift_empty          (tx_shift_empty),
	.tx_fifo_below_threshold (tx_fifo_below_threshold),
	.tx_before_stop          (tx_before_stop),
	.loopback_select         (loopback_select),
	.tx_from_uart            (tx_from_uart),
	.tx_pin                  (tx_pin),
	.driver_enable           (driver_enable),
	.tx_irq_request          (tx_irq_request),
	.rx_gate                 (rx_gate)
);
